//--- rtl/spv_top.sv
// spv_top: serial program/verify port of the on-chip program memory
// assumes the programmer owns the serial clock, data and mode select;
// the serial clock idles low between frames and at mode entry
`timescale 1ns/1ns
module spv_top
    import spv_pkg::*;
#(
    parameter int ERASE_CYCLES = ERASE_TIME_US * CORE_CLK_MHZ
) (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic prog_serial_clock_in,
    input wire logic prog_serial_data_in,
    output logic prog_serial_data_out,
    output logic prog_serial_data_oe_out,
    input wire logic prog_voltage_select_in,
    output logic core_logic_reset_out,
    output logic program_active_out,
    output logic erase_busy_out,
    output logic code_protect_n_out
);
    localparam int ECNT_W = $clog2(ERASE_CYCLES + 1);

    spv_link_if lnk();
    spv_mem_if mif();

    logic pvs_s1_q, pvs_s2_q, mode_q;
    logic cmd_s1_q, cmd_s2_q, cmd_s3_q;
    logic word_s1_q, word_s2_q, word_s3_q;
    logic [ADDR_W-1:0] addr_q;
    logic cfg_access_q;
    logic [WORD_W-1:0] load_q;
    logic load_valid_q;
    logic prog_active_q;
    logic wr_en_q;
    logic erase_start_q;
    logic erase_ids_q;
    logic [ECNT_W-1:0] erase_cnt_q;
    logic erase_busy_q;
    logic cp_n_q;

    logic cmd_ev_w, word_ev_w, busy_w, cmd_go_w;
    logic inc_go_w, read_go_w, begin_go_w, end_go_w, erase_go_w;
    logic in_user_w, in_id_w, cp_on_w;
    logic [WORD_W-1:0] read_val_w;
    spv_cmd_t cmd_kind_w;

    // mode select is a pin: three flops before anything reads it
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pvs_s1_q <= 1'b0;
            pvs_s2_q <= 1'b0;
            mode_q <= 1'b0;
        end else begin
            pvs_s1_q <= prog_voltage_select_in;
            pvs_s2_q <= pvs_s1_q;
            mode_q <= pvs_s2_q;
        end
    end

    // while in the mode the rest of the chip stays in reset
    assign core_logic_reset_out = mode_q;

    // link toggles: s1 feeds only s2, s3 remembers the last level.
    // cleared outside the mode so a link reset cannot fake an event
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cmd_s1_q <= 1'b0;
            cmd_s2_q <= 1'b0;
            cmd_s3_q <= 1'b0;
            word_s1_q <= 1'b0;
            word_s2_q <= 1'b0;
            word_s3_q <= 1'b0;
        end else if (!mode_q) begin
            cmd_s1_q <= 1'b0;
            cmd_s2_q <= 1'b0;
            cmd_s3_q <= 1'b0;
            word_s1_q <= 1'b0;
            word_s2_q <= 1'b0;
            word_s3_q <= 1'b0;
        end else begin
            cmd_s1_q <= lnk.cmd_tgl;
            cmd_s2_q <= cmd_s1_q;
            cmd_s3_q <= cmd_s2_q;
            word_s1_q <= lnk.word_tgl;
            word_s2_q <= word_s1_q;
            word_s3_q <= word_s2_q;
        end
    end

    // command decode; code and word are stable long before the toggle
    // lands, so they are read here without their own synchroniser
    assign cmd_ev_w = cmd_s2_q ^ cmd_s3_q;
    assign word_ev_w = word_s2_q ^ word_s3_q;
    assign cmd_kind_w = spv_decode(lnk.cmd_code);
    assign busy_w = (erase_cnt_q != '0) || mif.erase_busy;
    // while programming only end programming is heard
    assign cmd_go_w = cmd_ev_w && !busy_w &&
                      (!prog_active_q || cmd_kind_w == CMD_END);
    assign inc_go_w = cmd_go_w && (cmd_kind_w == CMD_INC);
    assign read_go_w = cmd_go_w && (cmd_kind_w == CMD_READ);
    assign begin_go_w = cmd_go_w && (cmd_kind_w == CMD_BEGIN) &&
                        load_valid_q;
    assign end_go_w = cmd_go_w && (cmd_kind_w == CMD_END);
    assign erase_go_w = cmd_go_w && (cmd_kind_w == CMD_ERASE);

    // address counter: 11 bits, so 3FF steps to 400 and 7FF to 000
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            addr_q <= ADDR_CFG_WORD;
            cfg_access_q <= 1'b1;
        end else if (!mode_q) begin
            addr_q <= ADDR_CFG_WORD;
            cfg_access_q <= 1'b1;
        end else if (inc_go_w) begin
            addr_q <= addr_q + ADDR_ONE;
            cfg_access_q <= 1'b0;
        end
    end

    // load word: top two bits of the frame are dropped
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            load_q <= WORD_ERASED;
            load_valid_q <= 1'b0;
        end else if (!mode_q) begin
            load_valid_q <= 1'b0;
        end else if (word_ev_w) begin
            load_q <= lnk.load_word[WORD_W-1:0];
            load_valid_q <= 1'b1;
        end else if (begin_go_w) begin
            load_valid_q <= 1'b0;
        end
    end

    // read value: user space hides behind protection, ids never do
    assign in_user_w = addr_q <= ADDR_USER_TOP;
    assign in_id_w = (addr_q >= ADDR_CFG_BASE) && (addr_q <= ADDR_ID_LAST);
    assign cp_on_w = ~mif.cfg_word[CP_BIT];
    assign read_val_w = (in_user_w && cp_on_w) ? WORD_ZERO :
                        mif.rd_data;

    // read word is held for the link until the next read command
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lnk.read_word <= '0;
        end else if (read_go_w) begin
            lnk.read_word <= {MSB_ZERO, read_val_w};
        end
    end

    // programming: one write at begin, the pulse runs until end
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prog_active_q <= 1'b0;
            wr_en_q <= 1'b0;
        end else if (!mode_q) begin
            prog_active_q <= 1'b0;
            wr_en_q <= 1'b0;
        end else begin
            wr_en_q <= begin_go_w;
            if (begin_go_w) begin
                prog_active_q <= 1'b1;
            end else if (end_go_w) begin
                prog_active_q <= 1'b0;
            end
        end
    end

    // bulk erase: ids and trim go only when the counter sits at 400
    // or above with the config word already locked away
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            erase_start_q <= 1'b0;
            erase_ids_q <= 1'b0;
            erase_cnt_q <= '0;
        end else begin
            erase_start_q <= erase_go_w;
            if (erase_go_w) begin
                erase_ids_q <= (addr_q >= ADDR_CFG_BASE) &&
                               !cfg_access_q;
                erase_cnt_q <= ECNT_W'(ERASE_CYCLES);
            end else if (erase_cnt_q != '0) begin
                erase_cnt_q <= ECNT_W'(erase_cnt_q - 1'b1);
            end
        end
    end

    // status outputs, all registered
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            erase_busy_q <= 1'b0;
            cp_n_q <= 1'b1;
        end else begin
            erase_busy_q <= busy_w;
            cp_n_q <= mif.cfg_word[CP_BIT];
        end
    end

    assign program_active_out = prog_active_q;
    assign erase_busy_out = erase_busy_q;
    assign code_protect_n_out = cp_n_q;

    // memory side
    assign mif.addr = addr_q;
    assign mif.wr_en = wr_en_q;
    assign mif.wr_data = load_q;
    assign mif.cfg_open = cfg_access_q;
    assign mif.erase_start = erase_start_q;
    assign mif.erase_ids = erase_ids_q;

    // link held in reset outside the mode; the serial clock is low
    // then, so release needs no synchroniser on that clock
    spv_link u_link (
        .link_clk_in(prog_serial_clock_in),
        .link_rst_n_in(mode_q),
        .sdata_in(prog_serial_data_in),
        .sdata_out(prog_serial_data_out),
        .sdata_oe_out(prog_serial_data_oe_out),
        .lnk(lnk.link)
    );

    spv_mem #(
        .DEPTH(USER_DEPTH)
    ) u_mem (
        .clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .mp(mif.mem)
    );

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!nrst_in);

    sequence s_inc_taken;
        mode_q && inc_go_w;
    endsequence

    sequence s_read_taken;
        mode_q && read_go_w;
    endsequence

    a_entry_addr: assert property (
        !mode_q |=> (addr_q == ADDR_CFG_WORD) && cfg_access_q)
        else $error("mode entry did not load 7FF");
    a_entry_quiet: assert property (
        (!mode_q ##1 !mode_q) |-> !prog_serial_data_oe_out &&
                                  !program_active_out)
        else $error("pin or programming active outside mode");
    a_inc_step: assert property (
        s_inc_taken |=> addr_q == ADDR_W'($past(addr_q) + ADDR_ONE))
        else $error("increment did not add one");
    a_user_skip: assert property (
        (s_inc_taken and (addr_q == ADDR_USER_TOP)) |=>
        addr_q == ADDR_CFG_BASE)
        else $error("3FF did not step to 400");
    a_cfg_lock: assert property (
        s_inc_taken ##1 (mode_q && !inc_go_w) |-> !cfg_access_q)
        else $error("config word still open after increment");
    a_read_shape: assert property (
        s_read_taken |=> lnk.read_word[FRAME_W-1:WORD_W] == MSB_ZERO &&
        (($past(in_user_w) && $past(cp_on_w)) ||
         lnk.read_word[WORD_W-1:0] == $past(mif.rd_data)))
        else $error("read word malformed");
    a_protect_zero: assert property (
        (s_read_taken and (in_user_w && cp_on_w)) |=>
        lnk.read_word == '0)
        else $error("protected read leaked data");
    a_id_visible: assert property (
        (s_read_taken and in_id_w) |=>
        lnk.read_word[WORD_W-1:0] == $past(mif.rd_data))
        else $error("id word hidden by protection");
    a_nop_stable: assert property (
        (cmd_go_w && cmd_kind_w == CMD_NOP) |=>
        $stable(addr_q) && !wr_en_q && !erase_start_q)
        else $error("undefined command had an effect");
    a_erase_scope: assert property (
        (erase_go_w && addr_q <= ADDR_USER_TOP) |=>
        erase_start_q && !erase_ids_q ##1 erase_busy_out)
        else $error("user-space erase reached ids or trim");
endmodule // spv_top

//--- inc/spv_pkg.sv
// spv_pkg: constants, command codes and decode for the program port
// assumes an 11-bit address space and 12-bit stored words
package spv_pkg;
    localparam int ADDR_W = 11;
    localparam int WORD_W = 12;
    localparam int FRAME_W = 14;
    localparam int CMD_W = 6;
    localparam int USER_DEPTH = 1024;
    localparam int CFG_DEPTH = 5; // four id words plus backup trim
    localparam int CFG_IDX_W = $clog2(CFG_DEPTH);
    localparam int CP_BIT = 4; // active-low code protect in config word
    localparam int CORE_CLK_MHZ = 10;
    localparam int ERASE_TIME_US = 200;
    localparam logic [10:0] ADDR_USER_TOP = 11'h3FF;
    localparam logic [10:0] ADDR_CFG_BASE = 11'h400;
    localparam logic [10:0] ADDR_ID_LAST = 11'h403;
    localparam logic [10:0] ADDR_TRIM = 11'h404;
    localparam logic [10:0] ADDR_CFG_TOP = 11'h43F;
    localparam logic [10:0] ADDR_CFG_WORD = 11'h7FF;
    localparam logic [10:0] ADDR_ONE = 11'h001;
    localparam logic [11:0] WORD_ERASED = 12'hFFF;
    localparam logic [11:0] WORD_ZERO = 12'h000;
    localparam logic [1:0] MSB_ZERO = 2'h0;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
    localparam logic [3:0] CMD_LAST = 4'h5;
    localparam logic [3:0] DATA_FIRST = 4'h1;
    localparam logic [3:0] DATA_LAST = 4'hE;
    localparam logic [3:0] FRAME_LAST = 4'hF;
    localparam logic [3:0] OP_LOAD = 4'h2;
    localparam logic [3:0] OP_READ = 4'h4;
    localparam logic [3:0] OP_INC = 4'h6;
    localparam logic [3:0] OP_BEGIN = 4'h8;
    localparam logic [3:0] OP_END = 4'hE;
    localparam logic [3:0] OP_ERASE = 4'h9;

    typedef enum logic [2:0] {
        CMD_NOP, CMD_LOAD, CMD_READ, CMD_INC, CMD_BEGIN, CMD_END, CMD_ERASE
    } spv_cmd_t;

    // upper two code bits are don't care
    function automatic spv_cmd_t spv_decode(input logic [CMD_W-1:0] code);
        case (code[3:0])
            OP_LOAD: return CMD_LOAD;
            OP_READ: return CMD_READ;
            OP_INC: return CMD_INC;
            OP_BEGIN: return CMD_BEGIN;
            OP_END: return CMD_END;
            OP_ERASE: return CMD_ERASE;
            default: return CMD_NOP;
        endcase
    endfunction
endpackage

//--- inc/spv_if.sv
// spv_if: carriers between the core side, the serial link and memory
// assumes link signals are held stable while their toggle crosses
`timescale 1ns/1ns
interface spv_link_if import spv_pkg::*; ;
    logic [CMD_W-1:0] cmd_code;
    logic cmd_tgl;
    logic [FRAME_W-1:0] load_word;
    logic word_tgl;
    logic [FRAME_W-1:0] read_word;
    modport link (output cmd_code, cmd_tgl, load_word, word_tgl,
                  input read_word);
    modport core (input cmd_code, cmd_tgl, load_word, word_tgl,
                  output read_word);
endinterface

interface spv_mem_if import spv_pkg::*; ;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] rd_data;
    logic [WORD_W-1:0] wr_data;
    logic [WORD_W-1:0] cfg_word;
    logic wr_en;
    logic cfg_open;
    logic erase_start;
    logic erase_ids;
    logic erase_busy;
    modport mem (input addr, wr_data, wr_en, cfg_open, erase_start,
                 erase_ids, output rd_data, cfg_word, erase_busy);
    modport core (output addr, wr_data, wr_en, cfg_open, erase_start,
                  erase_ids, input rd_data, cfg_word, erase_busy);
endinterface

//--- rtl/spv_link.sv
// spv_link: serial shifter on the programmer's clock
// assumes reset is held while the serial clock is still low
`timescale 1ns/1ns
module spv_link
    import spv_pkg::*;
(
    input wire logic link_clk_in,
    input wire logic link_rst_n_in,
    input wire logic sdata_in,
    output logic sdata_out,
    output logic sdata_oe_out,
    spv_link_if.link lnk
);
    typedef enum logic {PH_CMD, PH_FRAME} spv_phase_t;
    spv_phase_t phase_q;
    logic [3:0] cnt_q;
    logic [CMD_W-1:0] cmd_sr_q;
    logic [FRAME_W-1:0] word_sr_q;
    logic frame_rd_q;
    logic [CMD_W-1:0] code_w;
    spv_cmd_t kind_w;
    logic cmd_last_w;
    logic drive_w;
    logic [3:0] bit_idx_w;

    // shift path and decode of the bit arriving now
    assign code_w = {sdata_in, cmd_sr_q[CMD_W-1:1]};
    assign kind_w = spv_decode(code_w);
    assign cmd_last_w = (phase_q == PH_CMD) && (cnt_q == CMD_LAST);
    assign drive_w = (phase_q == PH_FRAME) && frame_rd_q &&
                     (cnt_q >= DATA_FIRST) && (cnt_q <= DATA_LAST);
    assign bit_idx_w = cnt_q - DATA_FIRST;

    // sampling on falling edges; results cross by toggles
    always_ff @(negedge link_clk_in or negedge link_rst_n_in) begin
        if (!link_rst_n_in) begin
            phase_q <= PH_CMD;
            cnt_q <= CNT_ZERO;
            cmd_sr_q <= '0;
            word_sr_q <= '0;
            frame_rd_q <= 1'b0;
            lnk.cmd_code <= '0;
            lnk.cmd_tgl <= 1'b0;
            lnk.load_word <= '0;
            lnk.word_tgl <= 1'b0;
        end else begin
            case (phase_q)
                PH_CMD: begin
                    cmd_sr_q <= code_w;
                    cnt_q <= cmd_last_w ? CNT_ZERO : cnt_q + CNT_ONE;
                    if (cmd_last_w) begin
                        lnk.cmd_code <= code_w;
                        lnk.cmd_tgl <= ~lnk.cmd_tgl;
                        frame_rd_q <= (kind_w == CMD_READ);
                        if (kind_w == CMD_LOAD || kind_w == CMD_READ) begin
                            phase_q <= PH_FRAME;
                        end
                    end
                end
                PH_FRAME: begin
                    cnt_q <= cnt_q + CNT_ONE;
                    // start and stop bits are ignored
                    if (cnt_q >= DATA_FIRST && cnt_q <= DATA_LAST) begin
                        word_sr_q <= {sdata_in, word_sr_q[FRAME_W-1:1]};
                    end
                    if (cnt_q == FRAME_LAST) begin
                        phase_q <= PH_CMD;
                        cnt_q <= CNT_ZERO;
                        if (!frame_rd_q) begin
                            lnk.load_word <= word_sr_q;
                            lnk.word_tgl <= ~lnk.word_tgl;
                        end
                    end
                end
                default: phase_q <= PH_CMD;
            endcase
        end
    end

    // pin driven on rising edges 2 to 15, released at 16
    always_ff @(posedge link_clk_in or negedge link_rst_n_in) begin
        if (!link_rst_n_in) begin
            sdata_oe_out <= 1'b0;
            sdata_out <= 1'b0;
        end else begin
            sdata_oe_out <= drive_w;
            sdata_out <= drive_w & lnk.read_word[bit_idx_w];
        end
    end

    sequence s_read_start;
        phase_q == PH_FRAME && frame_rd_q && cnt_q == DATA_FIRST;
    endsequence

    a_read_drive: assert property (
        @(posedge link_clk_in) disable iff (!link_rst_n_in)
        s_read_start |=> sdata_oe_out [*8])
        else $error("read drive not held");
    a_stop_release: assert property (
        @(posedge link_clk_in) disable iff (!link_rst_n_in)
        (phase_q == PH_FRAME && cnt_q == FRAME_LAST) |=> !sdata_oe_out)
        else $error("pin not released at stop bit");
    a_pin_quiet: assert property (
        @(posedge link_clk_in) disable iff (!link_rst_n_in)
        sdata_oe_out |-> (phase_q == PH_FRAME && frame_rd_q))
        else $error("pin driven outside read frame");
    a_cmd_publish: assert property (
        @(negedge link_clk_in) disable iff (!link_rst_n_in)
        cmd_last_w |=> lnk.cmd_tgl != $past(lnk.cmd_tgl))
        else $error("sixth bit did not publish command");
    a_nop_no_frame: assert property (
        @(negedge link_clk_in) disable iff (!link_rst_n_in)
        (cmd_last_w && kind_w == CMD_NOP) |=> phase_q == PH_CMD)
        else $error("undefined command opened a frame");
endmodule // spv_link

//--- rtl/spv_mem.sv
// spv_mem: program, id, trim and config word storage with erase sweep
// assumes writes only arrive while no erase sweep runs
`timescale 1ns/1ns
module spv_mem
    import spv_pkg::*;
#(
    parameter int DEPTH = USER_DEPTH
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    spv_mem_if.mem mp
);
    localparam int UIDX_W = $clog2(DEPTH);
    // contents are nonvolatile, so the arrays take no reset
    logic [WORD_W-1:0] user_q [DEPTH];
    logic [WORD_W-1:0] cfg_q [CFG_DEPTH];
    logic [WORD_W-1:0] word_q;
    logic [UIDX_W-1:0] sweep_q;
    logic sweeping_q;
    logic user_w, cfg_w, cword_w;
    logic [UIDX_W-1:0] uidx_w;
    logic [CFG_IDX_W-1:0] cidx_w;
    logic [WORD_W-1:0] rd_sel_w;

    // address decode; reserved space and a locked config word read ones
    assign user_w = mp.addr <= ADDR_USER_TOP;
    assign cfg_w = (mp.addr >= ADDR_CFG_BASE) && (mp.addr <= ADDR_TRIM);
    assign cword_w = (mp.addr == ADDR_CFG_WORD) && mp.cfg_open;
    assign uidx_w = mp.addr[UIDX_W-1:0];
    assign cidx_w = CFG_IDX_W'(mp.addr - ADDR_CFG_BASE);
    assign rd_sel_w = user_w ? user_q[uidx_w] :
                      cfg_w ? cfg_q[cidx_w] :
                      cword_w ? word_q : WORD_ERASED;
    assign mp.cfg_word = word_q;
    assign mp.erase_busy = sweeping_q;

    // registered read and the erase sweep, one word per cycle
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mp.rd_data <= WORD_ERASED;
            sweeping_q <= 1'b0;
            sweep_q <= '0;
        end else begin
            mp.rd_data <= rd_sel_w;
            if (mp.erase_start) begin
                sweeping_q <= 1'b1;
                sweep_q <= '0;
            end else if (sweeping_q) begin
                sweep_q <= UIDX_W'(sweep_q + 1'b1);
                sweeping_q <= (sweep_q != UIDX_W'(DEPTH - 1));
            end
        end
    end

    // programming only clears bits; erase sets them
    always_ff @(posedge clk_in) begin
        if (sweeping_q) begin
            user_q[sweep_q] <= WORD_ERASED;
        end else if (mp.wr_en && user_w) begin
            user_q[uidx_w] <= user_q[uidx_w] & mp.wr_data;
        end
    end

    always_ff @(posedge clk_in) begin
        if (mp.erase_start) begin
            word_q <= WORD_ERASED;
            for (int i = 0; i < CFG_DEPTH; i++) begin
                if (mp.erase_ids) begin
                    cfg_q[i] <= WORD_ERASED;
                end
            end
        end else if (mp.wr_en && cfg_w) begin
            cfg_q[cidx_w] <= cfg_q[cidx_w] & mp.wr_data;
        end else if (mp.wr_en && cword_w) begin
            word_q <= word_q & mp.wr_data;
        end
    end
endmodule // spv_mem

//--- tb/spv_prog_model.sv
// spv_prog_model: programmer driving the serial clock and data pin
// assumes the device drives the data pin only while its enable is high
`timescale 1ns/1ns
module spv_prog_model (
    input wire logic oe_in,
    input wire logic dout_in,
    output logic sclk_out,
    output logic sdat_out
);
    logic drv_q = 1'b0; // clock and data low at mode entry
    // released pin shows the programmer's own level drv_q: no pull resistor
    always_comb sdat_out = oe_in ? dout_in : drv_q;
    initial sclk_out = 1'b0;

    // one bit: data settles, rise, fall; clock idles low between frames
    task automatic tick(input logic b);
        drv_q = b;
        #5 sclk_out = 1'b1;
        #15 sclk_out = 1'b0;
        #10;
    endtask

    // six bits lsb first, then a gap that also covers discharge
    task automatic send_cmd(input logic [5:0] c);
        for (int i = 0; i < 6; i++) tick(c[i]);
        drv_q = ~drv_q;
        #700 drv_q = 1'b0;
    endtask

    // start, fourteen bits lsb first, stop; enable sampled at three points
    task automatic frame(input logic [13:0] w, output logic [13:0] r,
                         output logic [2:0] oe);
        tick(1'b0);
        oe[2] = oe_in;
        for (int i = 0; i < 14; i++) begin
            drv_q = w[i];
            #5 sclk_out = 1'b1;
            #15 r[i] = sdat_out;
            if (i == 0) oe[1] = oe_in;
            sclk_out = 1'b0;
            #10;
        end
        tick(1'b0);
        oe[0] = oe_in;
        drv_q = ~drv_q;
        #700 drv_q = 1'b0;
    endtask
endmodule // spv_prog_model

//--- tb/serial_program_verify_port_bench.sv
// serial_program_verify_port_bench: self-checking bench for spv_top
// assumes spv_prog_model plays the programmer on the serial pins
`timescale 1ns/1ns
module serial_program_verify_port_bench;
    import spv_pkg::*;
    typedef struct {logic [5:0] code; logic [13:0] val;} spv_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sel = 1'b0;
    logic sclk, sdat, dout, oe, lrst, pact, ebusy, cpn;
    int failures = 0;
    int samples_checked = 0;
    logic [13:0] rd;
    logic [2:0] oes;
    // erase at 7FF, read, inc with don't-care bits, erase at 000,
    // program 000, no-op
    spv_row_t rows [11] = '{'{6'h09, 14'h0}, '{6'h04, 14'h0FFF},
        '{6'h36, 14'h0}, '{6'h09, 14'h0}, '{6'h04, 14'h0FFF},
        '{6'h02, 14'h3A5C},
        '{6'h08, 14'h0}, '{6'h0E, 14'h0}, '{6'h04, 14'h0A5C},
        '{6'h3F, 14'h0}, '{6'h04, 14'h0A5C}};

    always #50 clk = ~clk;
    spv_top #(.ERASE_CYCLES(1100)) spv_top_i (.core_clk_in(clk),
        .nrst_in(rst_n), .prog_serial_clock_in(sclk),
        .prog_serial_data_in(sdat), .prog_serial_data_out(dout),
        .prog_serial_data_oe_out(oe), .prog_voltage_select_in(sel),
        .core_logic_reset_out(lrst), .program_active_out(pact),
        .erase_busy_out(ebusy), .code_protect_n_out(cpn));
    spv_prog_model spv_prog_model_i (.oe_in(oe), .dout_in(dout),
        .sclk_out(sclk), .sdat_out(sdat));

    task automatic check(input string what, input logic [13:0] seen,
                         input logic [13:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // one command with its frame; erase waits out the busy flag
    task automatic run(input logic [5:0] c, input logic [13:0] v);
        spv_prog_model_i.send_cmd(c);
        if (c[3:0] == OP_LOAD) spv_prog_model_i.frame(v, rd, oes);
        if (c[3:0] == OP_READ) begin
            spv_prog_model_i.frame(14'h2AAA, rd, oes);
            check("read word", rd, v);
            check("pin enable", {11'h0, oes}, 14'h0002);
        end
        if (c[3:0] == OP_ERASE) begin
            check("erase busy", {13'h0, ebusy}, 14'h0001);
            while (ebusy !== 1'b0) @(posedge clk);
        end
        if (c[3:0] == OP_BEGIN) check("prog on", {13'h0, pact}, 14'h1);
        if (c[3:0] == OP_END) check("prog off", {13'h0, pact}, 14'h0);
    endtask

    // rows first, then boundary walk, id erase scope and protection
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk) sel = 1'b1;
        repeat (6) @(negedge clk);
        check("core held", {13'h0, lrst}, 14'h0001);
        foreach (rows[i]) run(rows[i].code, rows[i].val);
        repeat (1024) run(6'h06, 14'h0);
        run(6'h09, 14'h0);
        run(6'h04, 14'h0FFF);
        run(6'h02, 14'h3FF5);
        run(6'h08, 14'h0);
        run(6'h0E, 14'h0);
        run(6'h04, 14'h0FF5);
        @(negedge clk) sel = 1'b0;
        repeat (6) @(negedge clk);
        check("core held", {13'h0, lrst}, 14'h0000);
        sel = 1'b1;
        repeat (6) @(negedge clk);
        run(6'h04, 14'h0FFF);
        run(6'h02, 14'h0FEF);
        run(6'h08, 14'h0);
        run(6'h0E, 14'h0);
        run(6'h04, 14'h0FEF);
        check("protect flag", {13'h0, cpn}, 14'h0000);
        run(6'h06, 14'h0);
        run(6'h04, 14'h0000);
        give_verdict();
    end

    // watchdog well beyond the expected 1.3 ms of traffic
    initial begin
        #4000000;
        failures++;
        give_verdict();
    end
endmodule // serial_program_verify_port_bench
